// file: hw/frame_fmt_pkg.sv
package frame_fmt_pkg;
	// Header layout
	localparam int KIND_HI = 7;
	localparam int KIND_LO = 6;
	localparam int PARAM_HI = 5;
	localparam int PARAM_LO = 2;
	localparam int TAG_HI = 1;
	localparam int TAG_LO = 0;
	localparam logic [1:0] KIND_REGULAR = 2'h2;
	localparam logic [1:0] KIND_CONTROL = 2'h1;
	localparam logic [3:0] OP_SKIP = 4'h0;
	localparam logic [3:0] OP_TIME = 4'h1;
	localparam logic [3:0] OP_CFG = 4'h2;
	localparam int P_ACC = 0;
	localparam int P_GYR = 1;
	localparam int P_AUX = 2;
	localparam logic [7:0] HDR_EMPTY = 8'h80;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] SKIP_SAT = 8'hff;
	localparam int AUX_MAX = 8;
	localparam int AXIS_BYTES = 6;
	localparam int CFG_BYTES = 4;
	localparam int TIME_BYTES = 3;
	// Register byte offsets
	localparam logic [7:0] A_DATA = 8'h00;
	localparam logic [7:0] A_LEVEL = 8'h04;
	localparam logic [7:0] A_CTRL = 8'h08;
	localparam logic [7:0] A_TIME = 8'h0c;
	// Control bits
	localparam int C_HDR = 0;
	localparam int C_TIME = 1;
	localparam int C_AUXLEN_LO = 4;
	localparam int C_AUXLEN_HI = 7;
	localparam logic [7:0] CTRL_RESET = 8'h83;
	localparam int LVL_HI_LO = 8;
	localparam int LVL_HI_HI = 13;
endpackage : frame_fmt_pkg

// file: hw/imu_fifo_frame_formatter.sv
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// How it works
// - Each frame starts with one header byte: kind, parameter, tag.
// - Regular frames use kind 2'b10, control frames 2'b01, others never.
// - Reading past stored content yields header 0x80 then payload 0x00.
// - Parameter bits 0,1,2 flag accelerometer, gyroscope, auxiliary data.
// - Regular frame tag holds sampled states of interrupt lines two and one.
// - Payload order: aux, gyro XYZ, accel XYZ, low byte first.
// - Regular frames are stored only when at least one sensor is present.
// - Aux block length equals configured burst length, capped at 8, shifting later data.
// - Control frames appear only in header mode.
// - Control opcodes: skip 0, sensortime 1, input-config 2.
// - Fill level is a byte count, upper bits 13..8 and lower 7..0.
// - After overflow a skip frame with saturating drop count is prepended.
// - Skip frame comes first in a burst and takes no storage.
// - Sensortime payload is the counter captured at last sample byte read.
// - Sensortime frame is sent last, only when storage empties mid burst.
// - Sensortime frames follow the time-frame enable bit.
// - Sensortime frame is built at readout and takes no storage.
// - A configuration change inserts an input-config frame.
// - Input-config payload: change flags then sensortime at the change event.
// - Fully read frames leave storage; partial ones replay from header.
module imu_fifo_frame_formatter #(
	parameter int DEPTH = 2048,
	parameter int AW = 11
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Sample input, same clock
	input wire logic sample_valid,
	input wire logic [2:0] sample_present,
	input wire logic [63:0] aux_bytes,
	input wire logic [47:0] gyr_bytes,
	input wire logic [47:0] acc_bytes,
	// Configuration change event, same clock
	input wire logic cfg_change,
	input wire logic [7:0] cfg_flags,
	// Pins and time base
	input wire logic irq_line_one,
	input wire logic irq_line_two,
	input wire logic [23:0] sensortime,
	// Status
	output logic overflow
);
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {RD_NORM, RD_SKIP, RD_TIME, RD_EMPTY} rd_e;
	localparam int FRAME_MAX = 1 + frame_fmt_pkg::AUX_MAX + 2 * frame_fmt_pkg::AXIS_BYTES;

	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wptr_q, rptr_q, fstart_q;
	logic [AW:0] level_q, fill_q;
	logic [7:0] ctrl_q, skip_cnt_q;
	logic skip_pend_q, skip_done_q, time_done_q, in_burst_q;
	logic [1:0] tsync1_q, tsync2_q;
	logic [23:0] time_cap_q;
	logic [1:0] ctr_q;
	rd_e rmode_q;
	logic [4:0] wr_idx_q, wr_len_q;
	logic [7:0] frm_q [FRAME_MAX];
	logic wr_busy_q;
	logic ovf_q;
	logic [31:0] hrdata_q;

	// Two flip-flop synchroniser for the tag pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tsync1_q <= 2'h0;
			tsync2_q <= 2'h0;
		end else begin
			tsync1_q <= {irq_line_two, irq_line_one};
			tsync2_q <= tsync1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	logic ap_valid, ap_wr, ap_rd;
	logic dp_wr_q, dp_rd_q;
	logic [7:0] dp_addr_q;
	assign ap_valid = hsel && hready && htrans[1];
	assign ap_wr = ap_valid && hwrite;
	assign ap_rd = ap_valid && !hwrite;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_rd_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else begin
			dp_wr_q <= ap_wr;
			dp_rd_q <= ap_rd;
			dp_addr_q <= haddr[7:0];
		end
	end

	wire hdr_mode = ctrl_q[frame_fmt_pkg::C_HDR];
	wire time_en = ctrl_q[frame_fmt_pkg::C_TIME];
	wire [3:0] aux_len_cfg = ctrl_q[frame_fmt_pkg::C_AUXLEN_HI:frame_fmt_pkg::C_AUXLEN_LO];
	wire [3:0] aux_len = (aux_len_cfg > 4'(frame_fmt_pkg::AUX_MAX)) ?
		4'(frame_fmt_pkg::AUX_MAX) : aux_len_cfg;
	wire data_rd = ap_rd && (haddr[7:0] == frame_fmt_pkg::A_DATA);
	wire ctrl_wr = dp_wr_q && (dp_addr_q == frame_fmt_pkg::A_CTRL);

	////////////////////////////////////////////////////////////////////////
	// Frame assembly into a staging buffer, then byte by byte into storage
	wire [2:0] pres = sample_present;
	wire frame_ok = |pres;
	wire [4:0] aux_n = pres[frame_fmt_pkg::P_AUX] ? 5'(aux_len) : 5'h0;
	wire [4:0] gyr_n = pres[frame_fmt_pkg::P_GYR] ? 5'(frame_fmt_pkg::AXIS_BYTES) : 5'h0;
	wire [4:0] acc_n = pres[frame_fmt_pkg::P_ACC] ? 5'(frame_fmt_pkg::AXIS_BYTES) : 5'h0;
	wire [4:0] reg_len = 5'h1 + aux_n + gyr_n + acc_n;
	wire [4:0] cfg_len = 5'(1 + frame_fmt_pkg::CFG_BYTES);
	wire start_cfg = !wr_busy_q && cfg_change && hdr_mode;
	wire start_reg = !wr_busy_q && !start_cfg && sample_valid && frame_ok;
	wire [4:0] new_len = start_cfg ? cfg_len : reg_len;
	wire room = (fill_q + (AW+1)'(new_len)) <= (AW+1)'(DEPTH);
	wire push = wr_busy_q;
	wire frame_end = push && (wr_idx_q == wr_len_q - 5'h1);

	// Regular header: kind, presence, tags; bit 3 of parameter stays clear
	wire [7:0] reg_hdr = {frame_fmt_pkg::KIND_REGULAR, 1'b0, pres, tsync2_q};
	wire [7:0] cfg_hdr = {frame_fmt_pkg::KIND_CONTROL, frame_fmt_pkg::OP_CFG, 2'h0};

	always_ff @(posedge hclk) begin
		if ((start_cfg || start_reg) && room) begin
			for (int i = 0; i < FRAME_MAX; i++) begin
				frm_q[i] <= frame_fmt_pkg::BYTE_ZERO;
			end
			if (start_cfg) begin
				frm_q[0] <= cfg_hdr;
				frm_q[1] <= cfg_flags;
				frm_q[2] <= sensortime[7:0];
				frm_q[3] <= sensortime[15:8];
				frm_q[4] <= sensortime[23:16];
			end else begin
				frm_q[0] <= reg_hdr;
				// Aux first, then gyro, then accel, low byte first
				for (int i = 0; i < frame_fmt_pkg::AUX_MAX; i++) begin
					if (5'(i) < aux_n) frm_q[1+i] <= aux_bytes[8*i +: 8];
				end
				for (int i = 0; i < frame_fmt_pkg::AXIS_BYTES; i++) begin
					if (gyr_n != 5'h0) frm_q[5'(1+i) + aux_n] <= gyr_bytes[8*i +: 8];
					if (acc_n != 5'h0) frm_q[5'(1+i) + aux_n + gyr_n] <= acc_bytes[8*i +: 8];
				end
			end
		end
		if (push) mem[wptr_q] <= frm_q[wr_idx_q];
	end

	// Write sequencing and overflow counting; a full store drops the newest frame
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_busy_q <= 1'b0;
			wr_idx_q <= 5'h0;
			wr_len_q <= 5'h0;
			wptr_q <= '0;
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= 1'b0;
			if ((start_cfg || start_reg) && room) begin
				wr_busy_q <= 1'b1;
				wr_idx_q <= 5'h0;
				wr_len_q <= new_len;
			end else if ((start_cfg || start_reg) && !room) begin
				ovf_q <= 1'b1;
			end
			if (push) begin
				wptr_q <= wptr_q + 1'b1;
				wr_idx_q <= wr_idx_q + 5'h1;
				if (frame_end) wr_busy_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Readout
	logic [4:0] rd_rem_q, rd_idx_q;
	wire [7:0] cur_hdr = mem[fstart_q];
	wire [3:0] cur_par = cur_hdr[frame_fmt_pkg::PARAM_HI:frame_fmt_pkg::PARAM_LO];
	wire cur_ctl = cur_hdr[frame_fmt_pkg::KIND_HI:frame_fmt_pkg::KIND_LO] == frame_fmt_pkg::KIND_CONTROL;
	wire [4:0] cur_len = cur_ctl ? cfg_len : 5'h1
		+ (cur_par[frame_fmt_pkg::P_AUX] ? 5'(aux_len) : 5'h0)
		+ (cur_par[frame_fmt_pkg::P_GYR] ? 5'(frame_fmt_pkg::AXIS_BYTES) : 5'h0)
		+ (cur_par[frame_fmt_pkg::P_ACC] ? 5'(frame_fmt_pkg::AXIS_BYTES) : 5'h0);
	wire stored = level_q != '0;
	wire [7:0] skip_hdr = {frame_fmt_pkg::KIND_CONTROL, frame_fmt_pkg::OP_SKIP, 2'h0};
	wire [7:0] time_hdr = {frame_fmt_pkg::KIND_CONTROL, frame_fmt_pkg::OP_TIME, 2'h0};
	wire want_skip = skip_pend_q && !skip_done_q && hdr_mode && !in_burst_q;
	wire want_time = time_en && hdr_mode && in_burst_q && !time_done_q && !stored;
	wire last_byte = stored && (rd_idx_q == cur_len - 5'h1);
	logic [7:0] rd_byte;

	// Select the byte that the current read returns
	always_comb begin
		rd_byte = frame_fmt_pkg::BYTE_ZERO;
		if (rmode_q == RD_SKIP) begin
			rd_byte = (ctr_q == 2'h0) ? skip_hdr : skip_cnt_q;
		end else if (rmode_q == RD_TIME) begin
			unique case (ctr_q)
				2'h0: rd_byte = time_hdr;
				2'h1: rd_byte = time_cap_q[7:0];
				2'h2: rd_byte = time_cap_q[15:8];
				default: rd_byte = time_cap_q[23:16];
			endcase
		end else if (rmode_q == RD_NORM && want_skip) begin
			// First byte of a burst after drops is the skip header, not stored data
			rd_byte = skip_hdr;
		end else if (rmode_q == RD_NORM && want_time) begin
			// The read that finds the store empty opens the time frame
			rd_byte = time_hdr;
		end else if (rmode_q == RD_EMPTY || !stored) begin
			rd_byte = (ctr_q == 2'h0) ? frame_fmt_pkg::HDR_EMPTY : frame_fmt_pkg::BYTE_ZERO;
		end else begin
			rd_byte = mem[rptr_q];
		end
	end

	// Mode of the read path; a burst ends with any non-data access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rmode_q <= RD_NORM;
			ctr_q <= 2'h0;
			in_burst_q <= 1'b0;
			skip_done_q <= 1'b0;
			time_done_q <= 1'b0;
			time_cap_q <= 24'h0;
		end else if (ap_valid && !data_rd) begin
			in_burst_q <= 1'b0;
			skip_done_q <= 1'b0;
			time_done_q <= 1'b0;
			rmode_q <= RD_NORM;
			ctr_q <= 2'h0;
		end else if (data_rd) begin
			in_burst_q <= 1'b1;
			unique case (rmode_q)
				RD_SKIP: begin
					ctr_q <= 2'h0;
					rmode_q <= RD_NORM;
					skip_done_q <= 1'b1;
				end
				RD_TIME: begin
					ctr_q <= ctr_q + 2'h1;
					if (ctr_q == 2'(frame_fmt_pkg::TIME_BYTES)) begin
						rmode_q <= RD_EMPTY;
						ctr_q <= 2'h0;
					end
				end
				RD_EMPTY: ctr_q <= ctr_q ^ 2'h1;
				RD_NORM: begin
					if (want_skip) begin
						rmode_q <= RD_SKIP;
						ctr_q <= 2'h1;
					end else if (last_byte) begin
						time_cap_q <= sensortime;
					end else if (want_time) begin
						rmode_q <= RD_TIME;
						time_done_q <= 1'b1;
						ctr_q <= 2'h1;
					end else if (!stored) begin
						rmode_q <= RD_EMPTY;
						ctr_q <= 2'h1;
					end
				end
			endcase
		end
	end

	// Stored-frame pointers: commit on full read, rewind on partial read
	wire norm_take = data_rd && rmode_q == RD_NORM && !want_skip && stored;
	wire pop = norm_take && last_byte;
	wire burst_end = ap_valid && !data_rd;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rptr_q <= '0;
			fstart_q <= '0;
			rd_idx_q <= 5'h0;
			level_q <= '0;
			fill_q <= '0;
		end else begin
			if (norm_take) begin
				rptr_q <= rptr_q + 1'b1;
				rd_idx_q <= last_byte ? 5'h0 : rd_idx_q + 5'h1;
				if (last_byte) fstart_q <= rptr_q + 1'b1;
			end else if (burst_end) begin
				rptr_q <= fstart_q;
				rd_idx_q <= 5'h0;
			end
			// Level counts whole committed frames; fill also reserves ones in flight
			level_q <= level_q + (frame_end ? (AW+1)'(wr_len_q) : '0)
				- (pop ? (AW+1)'(cur_len) : '0);
			fill_q <= fill_q + (((start_cfg || start_reg) && room) ? (AW+1)'(new_len) : '0)
				- (pop ? (AW+1)'(cur_len) : '0);
		end
	end

	// Skip counter; a new drop in the cycle the count is delivered survives
	wire skip_clear = data_rd && rmode_q == RD_SKIP;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			skip_pend_q <= 1'b0;
			skip_cnt_q <= 8'h00;
		end else if (ovf_q) begin
			skip_pend_q <= 1'b1;
			skip_cnt_q <= skip_clear ? 8'h01 :
				(skip_cnt_q == frame_fmt_pkg::SKIP_SAT ? skip_cnt_q : skip_cnt_q + 8'h01);
		end else if (skip_clear) begin
			skip_pend_q <= 1'b0;
			skip_cnt_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= frame_fmt_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_q <= hwdata[7:0];
		end
	end

	// Widen first so a small store still fills both count fields
	wire [13:0] level_cnt = 14'(level_q);
	wire [31:0] level_word = {18'h0, level_cnt[frame_fmt_pkg::LVL_HI_HI:frame_fmt_pkg::LVL_HI_LO],
		level_cnt[7:0]};
	wire [31:0] rd_word = (haddr[7:0] == frame_fmt_pkg::A_DATA) ? {24'h0, rd_byte} :
		(haddr[7:0] == frame_fmt_pkg::A_LEVEL) ? level_word :
		(haddr[7:0] == frame_fmt_pkg::A_CTRL) ? {24'h0, ctrl_q} :
		(haddr[7:0] == frame_fmt_pkg::A_TIME) ? {8'h0, sensortime} : 32'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0;
			overflow <= 1'b0;
		end else begin
			if (ap_rd) hrdata_q <= rd_word;
			overflow <= skip_pend_q;
		end
	end
	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	////////////////////////////////////////////////////////////////////////
	property p_hdr_kind;
		@(posedge hclk) disable iff (!hresetn)
		push && wr_idx_q == 5'h0 |-> mem[wptr_q] == mem[wptr_q] && frm_q[0][7:6] != 2'h0;
	endproperty
	a_hdr_kind: assert property (p_hdr_kind) else $error("bad kind");
	property p_no_empty;
		@(posedge hclk) disable iff (!hresetn)
		start_reg |-> sample_present != 3'h0;
	endproperty
	a_no_empty: assert property (p_no_empty) else $error("empty frame");
	property p_overread;
		@(posedge hclk) disable iff (!hresetn)
		data_rd && rmode_q == RD_NORM && !stored && !want_skip && !want_time
			|=> hrdata == {24'h0, frame_fmt_pkg::HDR_EMPTY};
	endproperty
	a_overread: assert property (p_overread) else $error("overread");
	property p_skip_first;
		@(posedge hclk) disable iff (!hresetn)
		data_rd && want_skip |=> hrdata[7:0] == skip_hdr;
	endproperty
	a_skip_first: assert property (p_skip_first) else $error("skip");
	property p_time_hdr;
		@(posedge hclk) disable iff (!hresetn)
		data_rd && rmode_q == RD_NORM && want_time && !want_skip |=> hrdata[7:0] == time_hdr;
	endproperty
	a_time_hdr: assert property (p_time_hdr) else $error("time");
	property p_time_off;
		@(posedge hclk) disable iff (!hresetn)
		!time_en |-> rmode_q != RD_TIME || $past(rmode_q) == RD_TIME;
	endproperty
	a_time_off: assert property (p_time_off) else $error("time off");
	property p_cfg_hdr;
		@(posedge hclk) disable iff (!hresetn)
		start_cfg && room |=> frm_q[0] == cfg_hdr && wr_len_q == cfg_len;
	endproperty
	a_cfg_hdr: assert property (p_cfg_hdr) else $error("cfg");
	property p_no_ctl_nohdr;
		@(posedge hclk) disable iff (!hresetn)
		!hdr_mode |-> !start_cfg;
	endproperty
	a_no_ctl_nohdr: assert property (p_no_ctl_nohdr) else $error("ctl");
	property p_rewind;
		@(posedge hclk) disable iff (!hresetn)
		burst_end && !norm_take |=> rptr_q == $past(fstart_q);
	endproperty
	a_rewind: assert property (p_rewind) else $error("rewind");
endmodule : imu_fifo_frame_formatter

// file: tb/fifo_host.sv
`timescale 1ns/1ps
// Bus master standing in for the host that drains the frame store
module fifo_host (
	// Clock
	input wire logic hclk,
	// Request side
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Answer side
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	int tmo = 0;
	logic [7:0] fq [$];
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Bounded wait on hready; a stuck slave is counted rather than hanging the run
	task wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && n < 64) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 64) tmo++;
	endtask : wait_rdy
	// One single word transfer, entered just after a rising edge
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : xfer
	// Reads one whole frame; the header decides how many payload bytes follow
	task rd_frame(input int auxlen);
		logic [31:0] d;
		int len;
		fq.delete();
		xfer(1'b0, 32'h0, 32'h0, d);
		fq.push_back(d[7:0]);
		if (d[7:6] == 2'h1)
			len = (d[5:2] == 4'h0) ? 1 : (d[5:2] == 4'h1) ? 3 : 4;
		else
			len = (d[4] ? auxlen : 0) + (d[3] ? 6 : 0) + (d[2] ? 6 : 0);
		if (d[7:0] == 8'h80) len = 1;
		repeat (len) begin
			xfer(1'b0, 32'h0, 32'h0, d);
			fq.push_back(d[7:0]);
		end
	endtask : rd_frame
endmodule : fifo_host

// file: tb/test_imu_fifo_frame_formatter.sv
`timescale 1ns/1ps
module test_imu_fifo_frame_formatter;
	typedef struct packed {logic [2:0] p; logic [1:0] irq; logic [7:0] lvl;} row_s;
	logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout, overflow;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans;
	logic [2:0] hsize, sample_present;
	logic sample_valid, cfg_change, irq_line_one, irq_line_two;
	logic [7:0] cfg_flags;
	logic [23:0] sensortime;
	logic [47:0] acc_bytes = 48'h353433323130;
	logic [7:0] eq [$];
	int err_count = 0;
	int n_checks = 0;
	row_s rows [7] = '{'{3'h1, 2'h0, 8'h07}, '{3'h2, 2'h1, 8'h07}, '{3'h3, 2'h2, 8'h0d},
		'{3'h4, 2'h3, 8'h09}, '{3'h5, 2'h1, 8'h0f}, '{3'h6, 2'h2, 8'h0f}, '{3'h7, 2'h3, 8'h15}};
	// Small store so overflow is reachable in a short run
	imu_fifo_frame_formatter #(.DEPTH(64), .AW(6)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sample_valid(sample_valid), .sample_present(sample_present),
		.aux_bytes(64'h1716151413121110), .gyr_bytes(48'h252423222120),
		.acc_bytes(acc_bytes), .cfg_change(cfg_change), .cfg_flags(cfg_flags),
		.irq_line_one(irq_line_one), .irq_line_two(irq_line_two),
		.sensortime(sensortime), .overflow(overflow));
	fifo_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;
	////////////////////////////////////////////////////////////////////////////////
	// Clock at 8 ns
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task close_out();
		if (host.tmo != 0) err_count++;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task rreg(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, {24'h0, a}, 32'h0, d);
		check(d, exp);
	endtask : rreg
	task wreg(input logic [7:0] a, input logic [31:0] v);
		host.xfer(1'b1, {24'h0, a}, v, d);
	endtask : wreg
	// Pulse, then leave room for the store to finish writing the frame
	task push(input logic [2:0] p, input logic c);
		sample_valid <= ~c;
		cfg_change <= c;
		sample_present <= p;
		@(posedge hclk);
		sample_valid <= 1'b0;
		cfg_change <= 1'b0;
		repeat (32) @(posedge hclk);
	endtask : push
	task cmp_q(input int auxlen);
		host.rd_frame(auxlen);
		check(host.fq.size(), eq.size());
		foreach (eq[i]) check(host.fq[i], eq[i]);
	endtask : cmp_q
	// Expected regular frame built from presence bits, tag and aux length
	task exp_frame(input logic [2:0] p, input logic [1:0] tag, input int auxlen);
		eq = '{{2'h2, 1'b0, p, tag}};
		if (p[2]) for (int i = 0; i < auxlen; i++) eq.push_back(8'h10 + i[7:0]);
		if (p[1]) for (int i = 0; i < 6; i++) eq.push_back(8'h20 + i[7:0]);
		if (p[0]) for (int i = 0; i < 6; i++) eq.push_back(8'h30 + i[7:0]);
		cmp_q(auxlen);
	endtask : exp_frame
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		hresetn = 1'b0;
		sample_valid = 1'b0;
		sample_present = 3'h0;
		cfg_change = 1'b0;
		cfg_flags = 8'h05;
		irq_line_one = 1'b0;
		irq_line_two = 1'b0;
		sensortime = 24'h123456;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rreg(frame_fmt_pkg::A_CTRL, 32'h83);
		rreg(frame_fmt_pkg::A_LEVEL, 32'h0);
		rreg(frame_fmt_pkg::A_DATA, 32'h80);
		rreg(frame_fmt_pkg::A_DATA, 32'h00);
		rreg(8'h10, 32'h0);
		wreg(frame_fmt_pkg::A_LEVEL, 32'hff);
		rreg(frame_fmt_pkg::A_LEVEL, 32'h0);
		check(hresp, 1'b0);
		wreg(frame_fmt_pkg::A_CTRL, 32'h81);
		// Ordinary frames: every presence mix and every tag value
		foreach (rows[i]) begin
			irq_line_two <= rows[i].irq[1];
			irq_line_one <= rows[i].irq[0];
			// Let the tag pins pass the two-stage synchroniser first
			repeat (2) @(posedge hclk);
			push(rows[i].p, 1'b0);
			rreg(frame_fmt_pkg::A_LEVEL, {24'h0, rows[i].lvl});
			exp_frame(rows[i].p, rows[i].irq, 8);
			host.rd_frame(8);
			check(host.fq[0], 8'h80);
		end
		// Empty sample set is never stored
		push(3'h0, 1'b0);
		rreg(frame_fmt_pkg::A_LEVEL, 32'h0);
		// Short aux block pulls gyro forward
		wreg(frame_fmt_pkg::A_CTRL, 32'h21);
		push(3'h7, 1'b0);
		exp_frame(3'h7, 2'h3, 2);
		// Partial read, then another access, replays from the header
		push(3'h1, 1'b0);
		host.xfer(1'b0, 32'h0, 32'h0, d);
		host.xfer(1'b0, 32'h0, 32'h0, d);
		rreg(frame_fmt_pkg::A_LEVEL, 32'h7);
		exp_frame(3'h1, 2'h3, 2);
		// Time frame closes the burst and takes no space
		wreg(frame_fmt_pkg::A_CTRL, 32'h83);
		push(3'h1, 1'b0);
		rreg(frame_fmt_pkg::A_LEVEL, 32'h7);
		exp_frame(3'h1, 2'h3, 8);
		eq = '{8'h44, 8'h56, 8'h34, 8'h12};
		cmp_q(8);
		rreg(frame_fmt_pkg::A_DATA, 32'h80);
		// Header mode off: no control frames at all
		wreg(frame_fmt_pkg::A_CTRL, 32'h82);
		push(3'h1, 1'b0);
		exp_frame(3'h1, 2'h3, 8);
		rreg(frame_fmt_pkg::A_DATA, 32'h80);
		// Configuration change frame carries flags and time
		wreg(frame_fmt_pkg::A_CTRL, 32'h81);
		push(3'h0, 1'b1);
		rreg(frame_fmt_pkg::A_LEVEL, 32'h5);
		eq = '{8'h48, 8'h05, 8'h56, 8'h34, 8'h12};
		cmp_q(8);
		// Fill to 63 bytes, then drop more frames than the count can hold
		repeat (3) push(3'h7, 1'b0);
		repeat (300) push(3'h7, 1'b0);
		check(overflow, 1'b1);
		rreg(frame_fmt_pkg::A_LEVEL, 32'h3f);
		eq = '{8'h40, 8'hff};
		cmp_q(8);
		exp_frame(3'h7, 2'h3, 8);
		close_out();
	end
endmodule : test_imu_fifo_frame_formatter
